// ---- bench/test_wdtc_core.sv ----
`timescale 1ns/1ps
module test_wdtc_core
  import wdtc_pkg::*;
();
  // ====
  // Stimulus and design
  typedef struct {logic [1:0] kind; logic [31:0] val; int lo; int hi;} wdtc_note_t;
  wdtc_note_t notes[$];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'hbff9;
  logic sys_clk, srst, clk_en, avs_read, avs_write, avs_waitrequest, irq, irq_a;
  logic low_freq_internal_osc, watchdog_clear_instr, sleep_enter, sleep_exit;
  logic osc_fail, crystal_startup_timer, wdt_reset_req, wdt_wake_req;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] watchdog_mode_cfg;
  logic [2:0] osc_div = 3'h0;
  wdtc_core u_wdtc_core (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .watchdog_mode_cfg(watchdog_mode_cfg),
    .low_freq_internal_osc(low_freq_internal_osc), .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_enter(sleep_enter), .sleep_exit(sleep_exit), .osc_fail(osc_fail),
    .crystal_startup_timer(crystal_startup_timer), .wdt_reset_req(wdt_reset_req),
    .wdt_wake_req(wdt_wake_req), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Slow oscillator: one rising edge every 8 system cycles, so windows are in units of 8
  always @(posedge sys_clk) begin
    osc_div <= osc_div + 3'h1;
    low_freq_internal_osc <= osc_div[2];
    cyc <= cyc + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic fail(input string msg);
    n_fail++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ====
  // Watcher: negedge sampling keeps comparisons clear of the launching edge
  task automatic check(input logic [1:0] kind, input logic [31:0] val);
    wdtc_note_t n;
    check_count++;
    if (notes.size() == 0) begin
      fail("result with no note");
    end else begin
      n = notes.pop_front();
      if (n.kind !== kind || n.val !== val || cyc < n.lo || cyc > n.hi) begin
        $display("wrong value at %0t: kind %0d data %h cycle %0d", $time, kind, val, cyc);
        n_fail++;
      end
    end
  endtask
  always @(negedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(2'h0, avs_readdata);
    if (wdt_reset_req === 1'b1) check(2'h1, 32'h0);
    if (wdt_wake_req === 1'b1) check(2'h2, 32'h0);
  end
  // ====
  // Bus and event tasks
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    if (!wr) notes.push_back('{2'h0, exp, cyc, cyc + 1000});
    for (int i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (avs_waitrequest !== 1'b0) fail("bus answer never came");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic pulse(input int which);
    @(posedge sys_clk);
    case (which)
      0: watchdog_clear_instr <= 1'b1;
      1: sleep_enter <= 1'b1;
      2: sleep_exit <= 1'b1;
      default: srst <= 1'b1;
    endcase
    @(posedge sys_clk);
    {watchdog_clear_instr, sleep_enter, sleep_exit, srst} <= 4'h0;
  endtask
  task automatic setup(input logic [1:0] mode, input logic [4:0] code, input logic en);
    pulse(3);
    bus(1'b1, 5'(WDTC_ADDR_CONTROL), {26'h0, code, en}, 32'h0);
    watchdog_mode_cfg <= mode;
  endtask
  // Window allows for the clear crossing into the oscillator domain
  task automatic expect_ev(input logic [1:0] kind, input int n);
    notes.push_back('{kind, 32'h0, cyc + (n - 1) * 8, cyc + (n + 8) * 8});
    for (int i = 0; i < 3000 && notes.size() > 0; i++) @(posedge sys_clk);
    watchdog_mode_cfg <= WDTC_MODE_OFF;
  endtask
  task automatic idle(input int n);
    repeat (n * 8) @(posedge sys_clk);
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail("run timed out");
    stop_test();
  end
  initial begin
    {srst, clk_en, avs_read, avs_write, avs_address, avs_writedata} = {2'h3, 39'h0};
    {watchdog_mode_cfg, watchdog_clear_instr, sleep_enter, sleep_exit} = 5'h0;
    {osc_fail, crystal_startup_timer, low_freq_internal_osc} = 3'h0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    bus(1'b0, 5'(WDTC_ADDR_CONTROL), 32'h0, 32'h16);
    bus(1'b1, 5'(WDTC_ADDR_CONTROL), 32'hffffffff, 32'h0);
    bus(0, 5'(WDTC_ADDR_CONTROL), 32'h0, 32'h3f);
    rnd = xs(rnd);
    bus(1'b1, 5'h14, rnd, 32'h0);
    bus(1'b0, 5'h14, 32'h0, 32'h0);
    bus(0, 5'(WDTC_ADDR_CONTROL), 32'h0, 32'h3f);
    setup(WDTC_MODE_ON, 5'h00, 1'b0);
    pulse(0);
    expect_ev(2'h1, 32);
    bus(1'b0, 5'(WDTC_ADDR_STATUS), 32'h0, 32'h08);
    bus(1'b0, 5'(WDTC_ADDR_IRQ_STAT), 32'h0, 32'h1);
    @(negedge sys_clk);
    irq_a = irq;
    bus(1'b1, 5'(WDTC_ADDR_IRQ_MASK), 32'h3, 32'h0);
    @(negedge sys_clk);
    check_count++;
    if ((irq ^ irq_a) !== 1'b1) fail("mask has no effect on irq");
    bus(1'b1, 5'(WDTC_ADDR_IRQ_STAT), 32'h3, 32'h0);
    bus(1'b0, 5'(WDTC_ADDR_IRQ_STAT), 32'h0, 32'h0);
    @(negedge sys_clk);
    check_count++;
    if (irq !== 1'b0) fail("irq stays after status clear");
    setup(WDTC_MODE_ON, 5'h01, 1'b1);
    pulse(0);
    expect_ev(2'h1, 64);
    rnd = xs(rnd);
    setup(WDTC_MODE_ON, 5'(19 + rnd % 13), 1'b1);
    pulse(0);
    expect_ev(2'h1, 32);
    setup(WDTC_MODE_ON, 5'h1f, 1'b1);
    pulse(0);
    expect_ev(2'h1, 32);
    setup(WDTC_MODE_SOFT, 5'h00, 1'b1);
    pulse(0);
    expect_ev(2'h1, 32);
    setup(WDTC_MODE_AWAKE, 5'h00, 1'b0);
    pulse(0);
    expect_ev(2'h1, 32);
    setup(WDTC_MODE_ON, 5'h00, 1'b0);
    pulse(1);
    expect_ev(2'h2, 32);
    bus(1'b0, 5'(WDTC_ADDR_STATUS), 32'h0, 32'h00);
    pulse(2);
    setup(WDTC_MODE_SOFT, 5'h00, 1'b1);
    pulse(1);
    expect_ev(2'h2, 32);
    pulse(2);
    setup(WDTC_MODE_OFF, 5'h00, 1'b1);
    idle(80);
    setup(WDTC_MODE_SOFT, 5'h00, 1'b0);
    idle(80);
    setup(WDTC_MODE_AWAKE, 5'h00, 1'b1);
    pulse(1);
    idle(80);
    pulse(2);
    setup(WDTC_MODE_ON, 5'h00, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      idle(20 + int'(rnd[1:0]));
      pulse(0);
    end
    osc_fail <= 1'b1;
    idle(80);
    osc_fail <= 1'b0;
    expect_ev(2'h1, 32);
    setup(WDTC_MODE_ON, 5'h00, 1'b1);
    pulse(1);
    pulse(2);
    crystal_startup_timer <= 1'b1;
    idle(80);
    crystal_startup_timer <= 1'b0;
    expect_ev(2'h1, 32);
    if (notes.size() != 0) fail("expected result never came");
    stop_test();
  end
endmodule // test_wdtc_core

// ---- rtl/wdtc_core.sv ----
`timescale 1ns/1ps
// Function
// - Mode 01: watchdog runs or stops by the software enable bit
// - Mode 01: sleep entry or exit does not change enable state
// - Mode 11: always active, also in sleep, software bit ignored
// - Mode 10: active while awake, disabled in sleep, software bit ignored
// - Counter held clear when mode 00, or mode 01 with enable low
// - Period select resets to code 01011, about two seconds
// - Code n up to 10010 gives prescale two to the (5+n)
// - Codes 10011 to 11111 act as the minimum 1:32 prescale
// - Clear on reset, clear instruction, oscillator fail, disable, start-up timer
// - Clear at sleep entry and at sleep exit
// - Enabled in sleep: counting resumes from zero after entry clear
// - After sleep exit, held clear until start-up timer finishes
// - Time-out in sleep wakes the device instead of resetting
// - Time-out updates active-low expiry and sleep flags
// - Time-out while awake generates a system reset
// - Prescaler runs from the low-frequency oscillator, not system clock
// - Clock switch or divider change leaves counter unaffected
// - Control bits 7 and 6 read as zero
module wdtc_core
  import wdtc_pkg::*;
#(
  parameter int CNT_W = WDTC_CNT_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] watchdog_mode_cfg,
  input wire logic low_freq_internal_osc,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic osc_fail,
  input wire logic crystal_startup_timer,
  output logic wdt_reset_req,
  output logic wdt_wake_req,
  output logic irq
);
  // ==========================================================================
  // Bus slave: one wait cycle per access, so answers come from flops
  typedef enum logic [1:0] {
    WDTC_IDLE = 2'b01,
    WDTC_ACK = 2'b10
  } wdtc_bus_t;
  wdtc_bus_t bus_state;
  logic [4:0] watchdog_period_select;
  logic soft_watchdog_on;
  logic expiry_flag_n;
  logic sleep_flag_n;
  logic asleep;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [31:0] rdata_q;
  wire req = avs_read | avs_write;
  // A write lands in the answer cycle, at the edge where waitrequest is low
  wire acc = req && (bus_state == WDTC_ACK);
  wire wr_acc = acc && avs_write;
  wire sel_ctrl = avs_address == {1'b0, WDTC_ADDR_CONTROL};
  wire sel_stat = avs_address == {1'b0, WDTC_ADDR_STATUS};
  wire sel_istat = avs_address == {1'b0, WDTC_ADDR_IRQ_STAT};
  wire sel_imask = avs_address == {1'b0, WDTC_ADDR_IRQ_MASK};
  wire sel_cmd = avs_address == WDTC_ADDR_CLEAR;
  wire sw_clear = wr_acc && sel_cmd && avs_writedata[WDTC_CMD_CLEAR_BIT];
  wire [7:0] ctrl_rd = {2'b00, watchdog_period_select, soft_watchdog_on};
  wire [7:0] stat_rd = {3'b000, expiry_flag_n, sleep_flag_n, 3'b000};
  wire [31:0] next_rdata = sel_ctrl ? {24'h0, ctrl_rd} :
                           sel_stat ? {24'h0, stat_rd} :
                           sel_istat ? {30'h0, irq_stat} :
                           sel_imask ? {30'h0, irq_mask} : 32'h0;
  assign avs_waitrequest = req && (bus_state != WDTC_ACK);
  assign avs_readdata = rdata_q;
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_state <= WDTC_IDLE;
      rdata_q <= 32'h0;
    end else if (clk_en) begin
      case (bus_state)
        WDTC_IDLE: begin
          if (req) begin
            bus_state <= WDTC_ACK;
            rdata_q <= next_rdata;
          end
        end
        WDTC_ACK: bus_state <= WDTC_IDLE;
        default: bus_state <= WDTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      watchdog_period_select <= WDTC_PS_RESET;
      soft_watchdog_on <= 1'b0;
      irq_mask <= 2'h0;
    end else if (clk_en && wr_acc && sel_ctrl) begin
      watchdog_period_select <= avs_writedata[WDTC_PS_MSB:WDTC_PS_LSB];
      soft_watchdog_on <= avs_writedata[WDTC_EN_BIT];
    end else if (clk_en && wr_acc && sel_imask) begin
      irq_mask <= avs_writedata[1:0];
    end
  end

  a_bus_wait: assert property (@(posedge sys_clk) disable iff (srst)
    (req && bus_state == WDTC_IDLE) |-> avs_waitrequest)
    else $error("request answered without wait state");

  a_wr_on_ack: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && avs_write && !avs_waitrequest && sel_ctrl)
    |=> soft_watchdog_on == $past(avs_writedata[WDTC_EN_BIT]))
    else $error("control write did not land on answer edge");

  a_ps_write: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && wr_acc && sel_ctrl)
    |=> watchdog_period_select == $past(avs_writedata[WDTC_PS_MSB:WDTC_PS_LSB]))
    else $error("period select write lost");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (srst)
    (avs_read && !avs_waitrequest && !(sel_ctrl || sel_stat || sel_istat || sel_imask))
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");


  // ==========================================================================
  // Enable decode in the system domain
  wire wdt_active = (watchdog_mode_cfg == WDTC_MODE_ON) ||
                    ((watchdog_mode_cfg == WDTC_MODE_AWAKE) && !asleep) ||
                    ((watchdog_mode_cfg == WDTC_MODE_SOFT) && soft_watchdog_on);
  // A clear request is a pulse; it is held by the pending bit below until the next oscillator edge
  wire clr_evt = watchdog_clear_instr | sw_clear | sleep_enter | sleep_exit;
  wire clr_level = osc_fail | crystal_startup_timer | !wdt_active;

  a_sleep_keeps: assert property (@(posedge sys_clk) disable iff (srst)
    (watchdog_mode_cfg == WDTC_MODE_SOFT && (sleep_enter || sleep_exit) && !wr_acc)
    ##1 (watchdog_mode_cfg == WDTC_MODE_SOFT) |-> wdt_active == $past(wdt_active))
    else $error("sleep changed soft mode enable");

  a_mode_off: assert property (@(posedge sys_clk) disable iff (srst)
    (watchdog_mode_cfg == WDTC_MODE_OFF) |-> !wdt_active && clr_level)
    else $error("mode 00 enables watchdog");


  // ==========================================================================
  // Crossing into the oscillator domain: toggle for events, two flops for levels
  logic clr_tog;
  logic [2:0] tog_sync;
  logic [1:0] hold_sync;
  logic [1:0] expire_sync;
  logic osc_d;
  wire osc_tick;
  logic clr_pend;
  logic [CNT_W-1:0] wdt_count;
  logic expire_tog;
  logic expire_seen;
  logic [4:0] ps_osc;

  // Events wait as a pending bit for the next oscillator edge; one toggle
  // per event would cancel out when two events fall between two edges.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clr_pend <= 1'b0;
      clr_tog <= 1'b0;
    end else if (clk_en) begin
      clr_pend <= (clr_pend && !osc_tick) || clr_evt;
      clr_tog <= clr_tog ^ (osc_tick && clr_pend);
    end
  end

  a_clr_pending: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && clr_evt) |=> clr_pend)
    else $error("clear event not held pending");

  a_clr_reaches: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && clr_pend) |=> clr_tog != $past(clr_tog))
    else $error("pending clear not passed on");


  // The oscillator is sampled as a synchronous enable so a switch of the
  // system clock source never touches the count.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_d <= 1'b0;
    end else if (clk_en) begin
      osc_d <= low_freq_internal_osc;
    end
  end
  assign osc_tick = low_freq_internal_osc && !osc_d;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tog_sync <= 3'b000;
      hold_sync <= 2'b11;
      ps_osc <= WDTC_PS_RESET;
    end else if (clk_en && osc_tick) begin
      tog_sync <= {tog_sync[1:0], clr_tog};
      hold_sync <= {hold_sync[0], clr_level};
      ps_osc <= watchdog_period_select;
    end
  end
  wire clr_osc = tog_sync[2] ^ tog_sync[1];
  wire hold_osc = hold_sync[1];

  // ==========================================================================
  // Prescaled counter; reserved codes fall back to the shortest period
  wire [4:0] ps_eff = (ps_osc > WDTC_PS_MAX) ? 5'h00 : ps_osc;
  wire [CNT_W-1:0] limit = CNT_W'((CNT_W'(1) << (ps_eff + 5'(WDTC_PS_BASE))) - CNT_W'(1));
  // At or above: a shorter period chosen mid-count must not let the count wrap
  wire expire_now = !hold_osc && !clr_osc && (wdt_count >= limit);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wdt_count <= '0;
      expire_tog <= 1'b0;
    end else if (clk_en && osc_tick) begin
      if (hold_osc || clr_osc) begin
        wdt_count <= '0;
      end else if (expire_now) begin
        wdt_count <= '0;
        expire_tog <= !expire_tog;
      end else begin
        wdt_count <= wdt_count + CNT_W'(1);
      end
    end
  end

  a_clr_zero: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && clr_osc) |=> wdt_count == '0)
    else $error("clear did not zero counter");

  a_resume_count: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && !hold_osc && !clr_osc && !expire_now)
    |=> wdt_count == $past(wdt_count) + CNT_W'(1))
    else $error("counter did not advance");

  a_expire_limit: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && expire_now) |=> expire_tog != $past(expire_tog))
    else $error("limit reached without expiry");

  a_startup_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && crystal_startup_timer) |=> hold_sync[0])
    else $error("start-up timer did not hold counter");

  a_osc_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && osc_fail) |=> hold_sync[0])
    else $error("oscillator fail did not hold counter");


  // ==========================================================================
  // Expiry back in the system side: reset when awake, wake when asleep
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      expire_sync <= 2'b00;
      expire_seen <= 1'b0;
    end else if (clk_en) begin
      expire_sync <= {expire_sync[0], expire_tog};
      expire_seen <= expire_sync[1];
    end
  end
  wire expire_evt = clk_en && (expire_sync[1] ^ expire_seen);
  wire next_reset_req = expire_evt && !asleep;
  wire next_wake_req = expire_evt && asleep;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wdt_reset_req <= 1'b0;
      wdt_wake_req <= 1'b0;
    end else if (clk_en) begin
      wdt_reset_req <= next_reset_req;
      wdt_wake_req <= next_wake_req;
    end
  end

  a_one_request: assert property (@(posedge sys_clk) disable iff (srst)
    !(wdt_reset_req && wdt_wake_req))
    else $error("reset and wake requested together");

  // Flags reload high on the first enabled clock after srst
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      asleep <= 1'b0;
    end else if (clk_en) begin
      if (sleep_enter) begin
        asleep <= 1'b1;
      end else if (sleep_exit || next_wake_req) begin
        asleep <= 1'b0;
      end
    end
  end

  a_sleep_enter: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && sleep_enter) |=> asleep)
    else $error("sleep entry not recorded");

  a_wake_awake: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && next_wake_req && !sleep_enter) |=> !asleep)
    else $error("wake did not leave sleep");


  logic flags_init;
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (!flags_init) begin
        expiry_flag_n <= 1'b1;
        sleep_flag_n <= 1'b1;
      end else if (expire_evt) begin
        expiry_flag_n <= 1'b0;
        sleep_flag_n <= !asleep;
      end else if (sleep_enter) begin
        sleep_flag_n <= 1'b0;
      end else if (watchdog_clear_instr || sw_clear) begin
        expiry_flag_n <= 1'b1;
        sleep_flag_n <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags_init <= 1'b0;
    end else if (clk_en) begin
      flags_init <= 1'b1;
    end
  end

  a_flags_awake: assert property (@(posedge sys_clk) disable iff (srst)
    (expire_evt && !asleep && flags_init) |=> !expiry_flag_n && sleep_flag_n)
    else $error("awake expiry flags wrong");

  a_flags_asleep: assert property (@(posedge sys_clk) disable iff (srst)
    (expire_evt && asleep && flags_init) |=> !expiry_flag_n && !sleep_flag_n)
    else $error("sleep expiry flags wrong");

  a_clr_flags: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && flags_init && watchdog_clear_instr && !expire_evt && !sleep_enter)
    |=> expiry_flag_n && sleep_flag_n)
    else $error("clear instruction did not raise flags");


  // Set wins over a write-one clear in the same cycle
  wire [1:0] irq_set = {next_wake_req, next_reset_req};
  wire [1:0] irq_clr = (wr_acc && sel_istat) ? avs_writedata[1:0] : 2'h0;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_stat <= 2'h0;
    end else if (clk_en) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  a_irq_set: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && next_reset_req) |=> irq_stat[WDTC_IRQ_RESET_BIT])
    else $error("reset event not recorded in status");


  // ==========================================================================
  // Checks
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst)
    (avs_read && !avs_waitrequest && sel_ctrl) |-> avs_readdata[7:6] == 2'b00)
    else $error("control bits 7-6 not zero");
  a_ps_reset: assert property (@(posedge sys_clk)
    $past(srst) |-> watchdog_period_select == WDTC_PS_RESET)
    else $error("period select reset value wrong");
  a_off_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (watchdog_mode_cfg == WDTC_MODE_OFF) [*3] |-> !wdt_active && clr_level)
    else $error("mode 00 not held clear");
  a_soft_en: assert property (@(posedge sys_clk) disable iff (srst)
    (watchdog_mode_cfg == WDTC_MODE_SOFT) |-> wdt_active == soft_watchdog_on)
    else $error("soft mode enable mismatch");
  a_on_sleep: assert property (@(posedge sys_clk) disable iff (srst)
    (watchdog_mode_cfg == WDTC_MODE_ON && asleep) |-> wdt_active)
    else $error("mode 11 inactive in sleep");
  a_awake_only: assert property (@(posedge sys_clk) disable iff (srst)
    (watchdog_mode_cfg == WDTC_MODE_AWAKE) |-> wdt_active == !asleep)
    else $error("mode 10 sleep gating wrong");
  a_hold_clear: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && osc_tick && hold_osc) |=> wdt_count == '0)
    else $error("counter not held clear");
  a_reserved_ps: assert property (@(posedge sys_clk) disable iff (srst)
    (ps_osc > WDTC_PS_MAX) |-> limit == CNT_W'(31))
    else $error("reserved code not minimum");
  a_sleep_wake: assert property (@(posedge sys_clk) disable iff (srst)
    (expire_evt && asleep) |=> wdt_wake_req && !wdt_reset_req)
    else $error("sleep expiry did not wake");
  a_awake_reset: assert property (@(posedge sys_clk) disable iff (srst)
    (expire_evt && !asleep) |=> wdt_reset_req ##1 !expiry_flag_n)
    else $error("awake expiry did not reset");
endmodule // wdtc_core

// ---- rtl/wdtc_pkg.sv ----
package wdtc_pkg;
  // ==========================================================================
  // Register map (word offsets are byte addresses)
  localparam logic [3:0] WDTC_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] WDTC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] WDTC_ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] WDTC_ADDR_IRQ_MASK = 4'hc;
  localparam logic [3:0] WDTC_ADDR_CMD = 4'h0;
  // ==========================================================================
  // Control register fields
  localparam int WDTC_EN_BIT = 0;
  localparam int WDTC_PS_LSB = 1;
  localparam int WDTC_PS_MSB = 5;
  localparam logic [4:0] WDTC_PS_RESET = 5'h0b;
  localparam logic [4:0] WDTC_PS_MAX = 5'h12;
  localparam int WDTC_PS_BASE = 5;
  // Status register fields
  localparam int WDTC_SLEEP_N_BIT = 3;
  localparam int WDTC_EXPIRY_N_BIT = 4;
  // Command register (offset 0x10) bits
  localparam logic [4:0] WDTC_ADDR_CLEAR = 5'h10;
  localparam int WDTC_CMD_CLEAR_BIT = 0;
  // Interrupt bits
  localparam int WDTC_IRQ_RESET_BIT = 0;
  localparam int WDTC_IRQ_WAKE_BIT = 1;
  // ==========================================================================
  // Mode field encodings
  localparam logic [1:0] WDTC_MODE_OFF = 2'h0;
  localparam logic [1:0] WDTC_MODE_SOFT = 2'h1;
  localparam logic [1:0] WDTC_MODE_AWAKE = 2'h2;
  localparam logic [1:0] WDTC_MODE_ON = 2'h3;
  localparam int WDTC_CNT_W = 28;
endpackage
